/* hw/cmic_pkg.sv */
// Package: command codes, field positions and reset values of the charger mode block
package cmic_pkg;

  // ****************************************
  // Command codes of the serial interface
  // ****************************************
  localparam logic [7:0] CMD_MODE    = 8'h12;
  localparam logic [7:0] CMD_CURRENT = 8'h14;
  localparam logic [7:0] CMD_VOLTAGE = 8'h15;
  localparam logic [7:0] CMD_INPUT   = 8'h3f;

  // ****************************************
  // Mode word field positions
  // ****************************************
  localparam int MODE_CHARGE_OFF = 0;
  localparam int MODE_RESTORE    = 2;
  localparam int MODE_ZERO       = 3;
  localparam int MODE_MASK_LSB   = 4;
  localparam int MODE_MASK_MSB   = 6;
  localparam int MODE_RELEARN    = 8;
  localparam int MODE_SHUTDOWN   = 10;

  // ****************************************
  // Status word field positions
  // ****************************************
  localparam int ST_CHARGE_OFF = 0;
  localparam int ST_LEVEL_2    = 4;
  localparam int ST_OVERTEMP   = 10;
  localparam int ST_ALARM      = 12;
  localparam int ST_EVENT_LSB  = 13;
  localparam int ST_EVENT_MSB  = 15;

  // ****************************************
  // Pin vector layout, event pins first
  // ****************************************
  localparam int PIN_MAINS_LOW = 0;
  localparam int PIN_PACK      = 1;
  localparam int PIN_ADAPTER   = 2;
  localparam int PIN_ABOVE     = 3;
  localparam int PIN_HOT       = 4;
  localparam int PIN_COUNT     = 5;
  localparam int EVENT_COUNT   = 3;

  // ****************************************
  // Values after reset and limits
  // ****************************************
  localparam logic [15:0] VOLTAGE_POR     = 16'h4b00;
  localparam logic [15:0] CURRENT_POR     = 16'h0080;
  localparam logic [15:0] INPUT_POR       = 16'h0080;
  localparam logic [15:0] INPUT_FLOOR     = 16'h0100;
  localparam logic [15:0] INPUT_KEEP_MASK = 16'h1f80;
  localparam logic        SHUTDOWN_POR    = 1'b1;

endpackage

/* hw/cmic_irq_if.sv */
// Interface: status levels, masks and acknowledge between control and attention logic
interface cmic_irq_if;
  logic [2:0] event_level;  // Mains-low, pack-present, adapter-present
  logic [2:0] event_mask;   // Same order as event_level
  logic       alert_ack;    // Alert response serviced
  logic       attention_n;  // Registered attention level

  modport ctrl (output event_level, output event_mask, output alert_ack, input attention_n);
  modport irq  (input event_level, input event_mask, input alert_ack, output attention_n);
endinterface

/* hw/cmic_sync.sv */
// Three-stage pin synchroniser that accepts a change once stages two and three agree
module cmic_sync
  import cmic_pkg::*;
#(
  parameter int W = PIN_COUNT
)
(
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         reset,
  // Raw pins and filtered levels
  input  wire logic [W-1:0] pin_async,
  output logic      [W-1:0] pin_level
);

  logic [W-1:0] s1_r, s2_r, s3_r, lvl_r, lvl_nxt;

  genvar i;
  for (i = 0; i < W; i++)
  begin : g_bit
    // Accept a new level only while the last two stages agree
    always_comb
    begin
      lvl_nxt[i] = (s2_r[i] == s3_r[i]) ? s3_r[i] : lvl_r[i];
    end

    // Shift chain and filtered level
    always_ff @(posedge clk)
    begin
      if (reset)
      begin
        s1_r[i]  <= 1'b0;
        s2_r[i]  <= 1'b0;
        s3_r[i]  <= 1'b0;
        lvl_r[i] <= 1'b0;
      end
      else
      begin
        s1_r[i]  <= pin_async[i];
        s2_r[i]  <= s1_r[i];
        s3_r[i]  <= s2_r[i];
        lvl_r[i] <= lvl_nxt[i];
      end
    end
  end

  assign pin_level = lvl_r;

endmodule

/* hw/cmic_irq.sv */
// Attention logic: masked change detection on status levels, held until alert response
module cmic_irq
  import cmic_pkg::*;
(
  // Clock and reset
  input  wire logic clk,
  input  wire logic reset,
  // Levels, masks and attention
  cmic_irq_if.irq   port
);

  logic [2:0] prev_r, prev_nxt;
  logic       primed_r, primed_nxt;
  logic       pend_r, pend_nxt;
  logic       attn_n_r, attn_n_nxt;
  logic [2:0] change;

  // Both edges of an unmasked level request attention; a new change beats the acknowledge
  always_comb
  begin
    change     = (port.event_level ^ prev_r) & ~port.event_mask & {3{primed_r}};
    prev_nxt   = port.event_level;
    primed_nxt = 1'b1;
    pend_nxt   = (pend_r & ~port.alert_ack) | (|change);
    attn_n_nxt = ~pend_nxt;
  end

  // Attention state
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      prev_r   <= 3'h0;
      primed_r <= 1'b0;
      pend_r   <= 1'b0;
      attn_n_r <= 1'b1;
    end
    else
    begin
      prev_r   <= prev_nxt;
      primed_r <= primed_nxt;
      pend_r   <= pend_nxt;
      attn_n_r <= attn_n_nxt;
    end
  end

  assign port.attention_n = attn_n_r;

  // ****************************************
  // Checks
  // ****************************************
  a_change_raises_attn: assert property (@(posedge clk) disable iff (reset)
    primed_r && |((port.event_level ^ prev_r) & ~port.event_mask) |=> !attn_n_r)
    else $error("Unmasked status change did not pull attention low");

  a_masked_stays_quiet: assert property (@(posedge clk) disable iff (reset)
    attn_n_r && !(|((port.event_level ^ prev_r) & ~port.event_mask)) |=> attn_n_r)
    else $error("Masked change pulled attention low");

  a_attn_held_no_ack: assert property (@(posedge clk) disable iff (reset)
    !attn_n_r && !port.alert_ack |=> !attn_n_r)
    else $error("Attention released without alert response");

  c_attention_low: cover property (@(posedge clk) disable iff (reset) $fell(attn_n_r));

endmodule

/* hw/cmic_top.sv */
// Charger mode word, set points, overtemp and alarm latches, source gates and attention
// Notes on behaviour
// - Mode bit 0 set latches charge off; bit 0 clear releases it; resets clear.
// - Only a mode word write changes the charge-off latch.
// - Mode bit 2 loads voltage 0x4B00 and current 0x0080; clear does nothing.
// - Mode bit 2 also clears the overtemp and alarm latches.
// - Mode bit 3 zeroes voltage and current set points regardless of charge-off.
// - Mode bits 4-6 mask adapter, pack, mains-low change interrupts; reset clear.
// - Bit 8 clear: adapter above pack gives adapter gate low, battery high.
// - Bit 8 set and adapter above pack: adapter gate high, battery low.
// - Mode bit 10, set at reset, lets the overtemp latch stop charging.
// - Overtemp latch clears on restore write or on pack removal.
// - Input limit requests of 1 to 256 mA become 256 mA.
// - Input limit holds its reset value until the host writes one.
// - Pack removal returns the input limit to its reset value.
// - Attention output is active low.
// - Changes of mains-low, pack-present or adapter-present request attention.
// - Command code 0x12 selects the mode word.
// - Pack removal sets mode bit 10 back to one.
// - Status bit 0 shows the charge-off latch.
module cmic_top
  import cmic_pkg::*;
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        reset,
  // Decoded write word from the serial engine
  input  wire logic        cmd_valid,
  input  wire logic [7:0]  cmd_code,
  input  wire logic [15:0] cmd_data,
  // Alert response and alarm events from the serial engine
  input  wire logic        alert_ack,
  input  wire logic        alarm_set,
  // Asynchronous pins and comparators
  input  wire logic        mains_low_pin,
  input  wire logic        pack_present_pin,
  input  wire logic        adapter_present_pin,
  input  wire logic        adapter_above_pack_pin,
  input  wire logic        overtemp_pin,
  // Status and set points
  output logic      [15:0] status_word,
  output logic      [15:0] voltage_setpoint,
  output logic      [15:0] current_setpoint,
  output logic      [15:0] input_limit_setpoint,
  // Power stage and source selection
  output logic             charge_enable,
  output logic             adapter_switch_gate,
  output logic             battery_switch_gate,
  // Attention request
  output logic             attention_n
);

  // ****************************************
  // Pin synchronisation
  // ****************************************
  logic [PIN_COUNT-1:0] pin_lvl;

  cmic_sync #(.W(PIN_COUNT)) u_sync (
    .clk       (clk),
    .reset     (reset),
    .pin_async ({overtemp_pin, adapter_above_pack_pin, adapter_present_pin,
                 pack_present_pin, mains_low_pin}),
    .pin_level (pin_lvl)
  );

  // ****************************************
  // State
  // ****************************************
  logic        charge_off_r, charge_off_nxt;
  logic [2:0]  mask_r, mask_nxt;
  logic        relearn_r, relearn_nxt;
  logic        shutdown_r, shutdown_nxt;
  logic        overtemp_r, overtemp_nxt;
  logic        alarm_r, alarm_nxt;
  logic        pack_prev_r, pack_prev_nxt;
  logic [15:0] voltage_r, voltage_nxt;
  logic [15:0] current_r, current_nxt;
  logic [15:0] input_r, input_nxt;
  logic [15:0] status_r, status_nxt;
  logic        enable_r, enable_nxt;
  logic        adapter_gate_r, adapter_gate_nxt;
  logic        battery_gate_r, battery_gate_nxt;
  logic        mode_wr;
  logic        pack_fall;
  logic        route_pack;

  // Command decode and pack removal event
  always_comb
  begin
    mode_wr   = cmd_valid && (cmd_code == CMD_MODE);
    pack_fall = pack_prev_r && !pin_lvl[PIN_PACK];
  end

  // ****************************************
  // Mode word fields
  // ****************************************
  // Unused mode bits are simply never looked at
  always_comb
  begin
    charge_off_nxt = charge_off_r;
    mask_nxt       = mask_r;
    relearn_nxt    = relearn_r;
    shutdown_nxt   = shutdown_r;
    if (mode_wr)
    begin
      charge_off_nxt = cmd_data[MODE_CHARGE_OFF];
      mask_nxt       = cmd_data[MODE_MASK_MSB:MODE_MASK_LSB];
      relearn_nxt    = cmd_data[MODE_RELEARN];
      shutdown_nxt   = cmd_data[MODE_SHUTDOWN];
    end
    // Removal of the pack wins over a mode write of bit 10 in the same cycle
    if (pack_fall)
    begin
      shutdown_nxt = SHUTDOWN_POR;
    end
  end

  // ****************************************
  // Latches: hardware set wins over clear
  // ****************************************
  always_comb
  begin
    overtemp_nxt = overtemp_r;
    alarm_nxt    = alarm_r;
    if ((mode_wr && cmd_data[MODE_RESTORE]) || pack_fall)
    begin
      overtemp_nxt = 1'b0;
      alarm_nxt    = 1'b0;
    end
    if (pin_lvl[PIN_HOT])
    begin
      overtemp_nxt = 1'b1;
    end
    if (alarm_set)
    begin
      alarm_nxt = 1'b1;
    end
    pack_prev_nxt = pin_lvl[PIN_PACK];
  end

  // ****************************************
  // Set points
  // ****************************************
  // Zeroing is applied after restore, so it wins when both bits are set
  always_comb
  begin
    voltage_nxt = voltage_r;
    current_nxt = current_r;
    input_nxt   = input_r;
    if (cmd_valid && cmd_code == CMD_VOLTAGE)
    begin
      voltage_nxt = cmd_data;
    end
    if (cmd_valid && cmd_code == CMD_CURRENT)
    begin
      current_nxt = cmd_data;
    end
    if (cmd_valid && cmd_code == CMD_INPUT)
    begin
      if (cmd_data != 16'h0000 && cmd_data <= INPUT_FLOOR)
      begin
        input_nxt = INPUT_FLOOR;
      end
      else
      begin
        input_nxt = cmd_data & INPUT_KEEP_MASK;
      end
    end
    if (mode_wr && cmd_data[MODE_RESTORE])
    begin
      voltage_nxt = VOLTAGE_POR;
      current_nxt = CURRENT_POR;
    end
    if (mode_wr && cmd_data[MODE_ZERO])
    begin
      voltage_nxt = 16'h0000;
      current_nxt = 16'h0000;
    end
    if (pack_fall)
    begin
      voltage_nxt = VOLTAGE_POR;
      current_nxt = CURRENT_POR;
      input_nxt   = INPUT_POR;
    end
  end

  // ****************************************
  // Outputs: enable, gates and status word
  // ****************************************
  always_comb
  begin
    // Overtemp stops charging only while its shutdown enable is set
    enable_nxt = !charge_off_nxt && !alarm_nxt
                 && !(shutdown_nxt && overtemp_nxt);
    // Relearn keeps the pack feeding the system even with the adapter above it
    route_pack       = pin_lvl[PIN_ABOVE] && !relearn_nxt;
    adapter_gate_nxt = !route_pack;
    battery_gate_nxt = route_pack;
    status_nxt                            = 16'h0000;
    status_nxt[ST_CHARGE_OFF]             = charge_off_nxt;
    status_nxt[ST_LEVEL_2]                = 1'b1;
    status_nxt[ST_OVERTEMP]               = overtemp_nxt;
    status_nxt[ST_ALARM]                  = alarm_nxt;
    status_nxt[ST_EVENT_MSB:ST_EVENT_LSB] = pin_lvl[EVENT_COUNT-1:0];
  end

  // Register all state
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      charge_off_r   <= 1'b0;
      mask_r         <= 3'h0;
      relearn_r      <= 1'b0;
      shutdown_r     <= SHUTDOWN_POR;
      overtemp_r     <= 1'b0;
      alarm_r        <= 1'b0;
      pack_prev_r    <= 1'b0;
      voltage_r      <= VOLTAGE_POR;
      current_r      <= CURRENT_POR;
      input_r        <= INPUT_POR;
      status_r       <= 16'h0010;
      enable_r       <= 1'b0;
      adapter_gate_r <= 1'b1;
      battery_gate_r <= 1'b0;
    end
    else
    begin
      charge_off_r   <= charge_off_nxt;
      mask_r         <= mask_nxt;
      relearn_r      <= relearn_nxt;
      shutdown_r     <= shutdown_nxt;
      overtemp_r     <= overtemp_nxt;
      alarm_r        <= alarm_nxt;
      pack_prev_r    <= pack_prev_nxt;
      voltage_r      <= voltage_nxt;
      current_r      <= current_nxt;
      input_r        <= input_nxt;
      status_r       <= status_nxt;
      enable_r       <= enable_nxt;
      adapter_gate_r <= adapter_gate_nxt;
      battery_gate_r <= battery_gate_nxt;
    end
  end

  assign status_word          = status_r;
  assign voltage_setpoint     = voltage_r;
  assign current_setpoint     = current_r;
  assign input_limit_setpoint = input_r;
  assign charge_enable        = enable_r;
  assign adapter_switch_gate  = adapter_gate_r;
  assign battery_switch_gate  = battery_gate_r;

  // ****************************************
  // Attention logic
  // ****************************************
  cmic_irq_if irq_bus ();

  assign irq_bus.event_level = pin_lvl[EVENT_COUNT-1:0];
  assign irq_bus.event_mask  = {mask_r[0], mask_r[1], mask_r[2]};
  assign irq_bus.alert_ack   = alert_ack;
  assign attention_n         = irq_bus.attention_n;

  cmic_irq u_irq (
    .clk   (clk),
    .reset (reset),
    .port  (irq_bus.irq)
  );

  // ****************************************
  // Checks
  // ****************************************
  a_charge_off_write: assert property (@(posedge clk) disable iff (reset)
    mode_wr |=> charge_off_r == $past(cmd_data[MODE_CHARGE_OFF]))
    else $error("Charge-off latch does not follow mode bit 0");

  a_charge_off_hold: assert property (@(posedge clk) disable iff (reset)
    !mode_wr |=> charge_off_r == $past(charge_off_r))
    else $error("Charge-off latch changed without a mode write");

  a_restore_loads: assert property (@(posedge clk) disable iff (reset)
    mode_wr && cmd_data[MODE_RESTORE] && !cmd_data[MODE_ZERO]
    |=> voltage_r == VOLTAGE_POR && current_r == CURRENT_POR)
    else $error("Restore did not load default set points");

  a_restore_clears: assert property (@(posedge clk) disable iff (reset)
    mode_wr && cmd_data[MODE_RESTORE] && !pin_lvl[PIN_HOT] && !alarm_set
    |=> !overtemp_r && !alarm_r)
    else $error("Restore did not clear overtemp and alarm latches");

  a_zero_setpoints: assert property (@(posedge clk) disable iff (reset)
    mode_wr && cmd_data[MODE_ZERO] && !pack_fall
    |=> voltage_r == 16'h0000 && current_r == 16'h0000)
    else $error("Zero bit did not clear set points");

  a_gates_select: assert property (@(posedge clk) disable iff (reset)
    ##1 adapter_gate_r == !battery_gate_r
    && battery_gate_r == ($past(pin_lvl[PIN_ABOVE]) && !relearn_r))
    else $error("Source gates disagree with comparator and relearn");

  a_relearn_gates: assert property (@(posedge clk) disable iff (reset)
    relearn_r && pin_lvl[PIN_ABOVE] && !mode_wr |=> adapter_gate_r && !battery_gate_r)
    else $error("Relearn did not keep battery routing");

  a_shutdown_off: assert property (@(posedge clk) disable iff (reset)
    shutdown_r && overtemp_r |-> !enable_r)
    else $error("Charger runs with overtemp and shutdown enabled");

  a_input_floor: assert property (@(posedge clk) disable iff (reset)
    cmd_valid && cmd_code == CMD_INPUT && cmd_data != 16'h0000
    && cmd_data <= INPUT_FLOOR && !pack_fall |=> input_r == INPUT_FLOOR)
    else $error("Low input limit not raised to the floor");

  a_pack_removal: assert property (@(posedge clk) disable iff (reset)
    pack_fall && !pin_lvl[PIN_HOT] |=> input_r == INPUT_POR && shutdown_r && !overtemp_r)
    else $error("Pack removal did not restore defaults");

  a_status_bit0: assert property (@(posedge clk) disable iff (reset)
    status_r[ST_CHARGE_OFF] == charge_off_r && status_r[ST_LEVEL_2])
    else $error("Status bit 0 differs from charge-off latch");

  c_mode_zero: cover property (@(posedge clk) disable iff (reset)
    mode_wr && cmd_data[MODE_ZERO]);
  c_pack_removed: cover property (@(posedge clk) disable iff (reset) pack_fall);
  c_relearn_route: cover property (@(posedge clk) disable iff (reset)
    relearn_r && pin_lvl[PIN_ABOVE]);
  c_overtemp_stop: cover property (@(posedge clk) disable iff (reset)
    overtemp_r && shutdown_r);

endmodule

/* testbench/cmic_host_model.sv */
// Host side model: issues decoded write words and alert responses
module cmic_host_model
  import cmic_pkg::*;
(
  // Clock
  input  wire logic        clk,
  // Write word and alert response
  output logic             cmd_valid,
  output logic      [7:0]  cmd_code,
  output logic      [15:0] cmd_data,
  output logic             alert_ack
);
  timeunit 1ns;
  timeprecision 1ns;

  // Idle lines at time zero
  initial
  begin
    cmd_valid = 1'b0;
    cmd_code  = 8'h00;
    cmd_data  = 16'h0000;
    alert_ack = 1'b0;
  end

  // One write word; the code picks the register, idle lines then show the inverse
  task automatic write_word(input logic [7:0] code, input logic [15:0] data);
    @(negedge clk);
    cmd_valid = 1'b1;
    cmd_code  = code;
    cmd_data  = data;
    @(negedge clk);
    cmd_valid = 1'b0;
    cmd_code  = ~code;
    cmd_data  = ~data;
  endtask

  // Alert response held high for one clock cycle
  task automatic ack();
    @(negedge clk);
    alert_ack = 1'b1;
    @(negedge clk);
    alert_ack = 1'b0;
  endtask
endmodule

/* testbench/charger_mode_and_interrupt_ctrl_test.sv */
// Testbench: mode word, set points, latches, source gates and attention
module charger_mode_and_interrupt_ctrl_test
  import cmic_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  logic        clk, reset, alarm_set, above, overtemp;
  logic [2:0]  ev_pin;  // Mains low, pack present, adapter present
  logic        cmd_valid, alert_ack;
  logic [7:0]  cmd_code;
  logic [15:0] cmd_data, status_word, voltage_setpoint, current_setpoint;
  logic [15:0] input_limit_setpoint;
  logic        charge_enable, adapter_switch_gate, battery_switch_gate, attention_n;
  int          errors, samples_checked;
  logic [15:0] lim_in  [4] = '{16'h0001, 16'h0100, 16'h0000, 16'h0800};
  logic [15:0] lim_exp [4] = '{16'h0100, 16'h0100, 16'h0000, 16'h0800};

  // Clock of 100 ns
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  cmic_host_model host (.clk(clk), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
    .cmd_data(cmd_data), .alert_ack(alert_ack));

  cmic_top uut (.clk(clk), .reset(reset), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
    .cmd_data(cmd_data), .alert_ack(alert_ack), .alarm_set(alarm_set),
    .mains_low_pin(ev_pin[0]), .pack_present_pin(ev_pin[1]),
    .adapter_present_pin(ev_pin[2]), .adapter_above_pack_pin(above),
    .overtemp_pin(overtemp), .status_word(status_word),
    .voltage_setpoint(voltage_setpoint), .current_setpoint(current_setpoint),
    .input_limit_setpoint(input_limit_setpoint), .charge_enable(charge_enable),
    .adapter_switch_gate(adapter_switch_gate), .battery_switch_gate(battery_switch_gate),
    .attention_n(attention_n));

  // Verdict and end of run
  task automatic test_done();
    $display("checks %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // Word compare
  task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      errors++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask

  // Single bit compare
  task automatic check_bit(input string name, input logic exp, input logic got);
    check(name, {15'h0000, exp}, {15'h0000, got});
  endtask

  task automatic wr(input logic [7:0] c, input logic [15:0] d);
    host.write_word(c, d);
  endtask

  // Pin change reaches the outputs five edges later
  task automatic settle();
    repeat (5) @(negedge clk);
  endtask

  // Bounded wait for the attention request
  task automatic wait_attn();
    int n;
    n = 0;
    while (attention_n !== 1'b0 && n < 8)
    begin
      @(negedge clk);
      n++;
    end
    check_bit("attention_n request", 1'b0, attention_n);
    if (attention_n !== 1'b0)
      test_done();
  endtask

  // Source gates against their expected levels
  task automatic gates(input logic adp);
    check_bit("adapter_switch_gate", adp, adapter_switch_gate);
    check_bit("battery_switch_gate", ~adp, battery_switch_gate);
  endtask

  // Main sequence
  initial
  begin
    reset     = 1'b1;
    alarm_set = 1'b0;
    above     = 1'b0;
    overtemp  = 1'b0;
    ev_pin    = 3'h0;
    repeat (12) @(negedge clk);
    reset = 1'b0;
    check("status reset", 16'h0010, status_word);
    check("voltage reset", VOLTAGE_POR, voltage_setpoint);
    check("current reset", CURRENT_POR, current_setpoint);
    check("input reset", INPUT_POR, input_limit_setpoint);
    check_bit("attention_n reset", 1'b1, attention_n);
    gates(1'b1);
    $display("test reset values done");

    wr(CMD_MODE, 16'h0001);
    check("status charge off", 16'h0011, status_word);
    check_bit("charge_enable off", 1'b0, charge_enable);
    wr(8'h13, 16'h0000);
    wr(CMD_CURRENT, 16'h0100);
    wr(CMD_VOLTAGE, 16'h3000);
    check("status other codes", 16'h0011, status_word);
    check("current written", 16'h0100, current_setpoint);
    check("voltage written", 16'h3000, voltage_setpoint);
    wr(CMD_MODE, 16'h0400);
    check("status charge on", 16'h0010, status_word);
    check_bit("charge_enable on", 1'b1, charge_enable);
    check("voltage kept", 16'h3000, voltage_setpoint);
    wr(CMD_MODE, 16'hfe82);
    check("status ignored bits", 16'h0010, status_word);
    check_bit("charge_enable ignored bits", 1'b1, charge_enable);
    gates(1'b1);
    $display("test charge off latch done");

    wr(CMD_MODE, 16'h0408);
    check("voltage zeroed", 16'h0000, voltage_setpoint);
    check("current zeroed", 16'h0000, current_setpoint);
    check("status zeroed", 16'h0010, status_word);
    wr(CMD_MODE, 16'h0400);
    check("voltage no change", 16'h0000, voltage_setpoint);
    wr(CMD_MODE, 16'h0404);
    check("voltage restored", 16'h4b00, voltage_setpoint);
    check("current restored", 16'h0080, current_setpoint);
    $display("test set points done");

    overtemp = 1'b1;
    settle();
    check("status overtemp", 16'h0410, status_word);
    check_bit("charge_enable shutdown", 1'b0, charge_enable);
    overtemp = 1'b0;
    settle();
    alarm_set = 1'b1;
    @(negedge clk);
    alarm_set = 1'b0;
    @(negedge clk);
    check("status latches held", 16'h1410, status_word);
    wr(CMD_MODE, 16'h0404);
    check("status latches cleared", 16'h0010, status_word);
    check_bit("charge_enable cleared", 1'b1, charge_enable);
    $display("test latches done");

    for (int i = 0; i < 4; i++)
    begin
      wr(CMD_INPUT, lim_in[i]);
      check("input limit", lim_exp[i], input_limit_setpoint);
    end
    $display("test input limit done");

    above = 1'b1;
    settle();
    gates(1'b0);
    wr(CMD_MODE, 16'h0500);
    gates(1'b1);
    wr(CMD_MODE, 16'h0400);
    gates(1'b0);
    above = 1'b0;
    settle();
    gates(1'b1);
    $display("test source gates done");

    for (int i = 0; i < 3; i++)
    begin
      wr(CMD_MODE, 16'h0400 | (16'h0040 >> i));
      ev_pin[i] = 1'b1;
      settle();
      check_bit("attention_n masked", 1'b1, attention_n);
      check("status event bits", 16'h2000 << i, status_word & 16'he000);
      wr(CMD_MODE, 16'h0400);
      ev_pin[i] = 1'b0;
      wait_attn();
      host.ack();
      check_bit("attention_n after ack", 1'b1, attention_n);
    end
    $display("test attention done");

    ev_pin[1] = 1'b1;
    wait_attn();
    host.ack();
    wr(CMD_INPUT, 16'h0800);
    wr(CMD_MODE, 16'h0000);
    overtemp = 1'b1;
    settle();
    overtemp = 1'b0;
    settle();
    check_bit("overtemp latch", 1'b1, status_word[ST_OVERTEMP]);
    check_bit("charge_enable no shutdown", 1'b1, charge_enable);
    ev_pin[1] = 1'b0;
    settle();
    check("input after removal", INPUT_POR, input_limit_setpoint);
    check_bit("overtemp after removal", 1'b0, status_word[ST_OVERTEMP]);
    check_bit("attention_n removal", 1'b0, attention_n);
    overtemp = 1'b1;
    settle();
    check_bit("shutdown after removal", 1'b0, charge_enable);
    overtemp = 1'b0;
    $display("test pack removal done");
    test_done();
  end
endmodule
